// *** dual_clock_fifo_prog_flags_tb.sv ***
/*
 dual_clock_fifo_prog_flags_tb: self-checking bench for fco_fifo through its pins and apb.
 assumes: single 25 MHz clock, depth and offsets as set in fco_pkg.
*/
`timescale 1ns/1ps
module dual_clock_fifo_prog_flags_tb;
	localparam int D = fco_pkg::FCO_DEPTH; // fifo depth
	localparam int OFF = int'(fco_pkg::FCO_DEF_OFF); // default offsets
	logic clock = 1'b0;
	logic rstn = 1'b0;
	logic mode_n = 1'b0; // low: enhanced
	logic wen2 = 1'b1;
	logic ren2 = 1'b1;
	logic oe_n = 1'b0;
	logic ld_n = 1'b1;
	logic rt = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic wen_n, ren_n, ff_n, af_n, hf_n, ae_n, ef_n, pready, pslverr, e;
	logic q_oe, wxo_n, rxo_n; // output enable and expansion flag copies
	logic [17:0] wdata, rdata, q;
	logic [31:0] prdata, v;
	int bad_count = 0;
	int total_checks = 0;
	// free-running clock, 40 ns period
	always #20 clock = ~clock;
	fco_fifo i_fco_fifo (.clock(clock), .rstn(rstn), .enhanced_mode_select_n(mode_n), .write_enable_n(wen_n),
		.write_expansion_in_or_enable2(wen2), .write_data_in(wdata), .read_enable_n(ren_n),
		.read_expansion_in_or_enable2(ren2), .output_enable_n(oe_n), .register_load_select_n(ld_n),
		.first_load_retransmit(rt), .read_data_out(rdata), .read_data_oe(q_oe), .full_flag_n(ff_n),
		.almost_full_flag_n(af_n), .half_full_flag_n(hf_n), .almost_empty_flag_n(ae_n), .empty_flag_n(ef_n),
		.write_expansion_out_half_full(wxo_n), .read_expansion_out_empty2(rxo_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	fco_peer i_fco_peer (.clock(clock), .write_enable_n(wen_n), .write_data_in(wdata), .read_enable_n(ren_n),
		.read_data_out(rdata));
	// compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	// verdict and end of run
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// one apb transfer; the wait for pready is bounded
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			bad_count++;
			wrap_up();
		end
		v = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// word pattern using all 18 bits
	function automatic logic [17:0] pat(input int i);
		return 18'(i * 37) ^ 18'h2a5a5;
	endfunction
	// occupancy flags for a count, default offsets
	task automatic flags(input int n);
		logic [4:0] x;
		repeat (3) @(posedge clock);
		x = {n != D, (D - n) > OFF, n <= D / 2, n > OFF, n != 0};
		chk({27'h0, ff_n, af_n, hf_n, ae_n, ef_n}, {27'h0, x}, "flags");
		chk({30'h0, wxo_n, rxo_n}, {30'h0, x[2], x[0]}, "expansion flags");
	endtask
	// main sequence
	initial begin
		repeat (6) @(posedge clock);
		chk({27'h0, ff_n, af_n, hf_n, ae_n, ef_n}, 32'h1c, "reset flags");
		rstn <= 1'b1;
		repeat (2) @(posedge clock);
		apb(1'b0, fco_pkg::FCO_A_CTRL, 32'h0);
		chk(v, 32'h3f, "ctrl");
		apb(1'b0, fco_pkg::FCO_A_EOFF, 32'h0);
		chk(v, 32'(OFF), "empty offset");
		apb(1'b0, fco_pkg::FCO_A_FOFF, 32'h0);
		chk(v, 32'(OFF), "full offset");
		$display("test reset done");
		// fill to full, one extra word dropped, then drain in order
		for (int i = 1; i <= D; i++) begin
			i_fco_peer.put_word(pat(i));
			flags(i);
		end
		i_fco_peer.put_word(18'h0);
		apb(1'b0, fco_pkg::FCO_A_STAT, 32'h0);
		chk(v & 32'h7ff, 32'(D), "count full");
		for (int i = 1; i <= D; i++) begin
			i_fco_peer.take_word(q);
			chk({14'h0, q}, {14'h0, pat(i)}, "word");
			flags(D - i);
		end
		$display("test fill drain done");
		// second enable low blocks writes
		wen2 <= 1'b0;
		i_fco_peer.put_word(18'h3ffff);
		apb(1'b0, fco_pkg::FCO_A_STAT, 32'h0);
		chk(v & 32'h7ff, 32'h0, "count enable2");
		wen2 <= 1'b1;
		i_fco_peer.put_word(18'h3ffff);
		// read suppression while outputs disabled
		apb(1'b1, fco_pkg::FCO_A_CTRL, 32'h2);
		apb(1'b0, fco_pkg::FCO_A_CTRL, 32'h0);
		chk(v, 32'h2, "ctrl rewrite");
		oe_n <= 1'b1;
		i_fco_peer.take_word(q);
		chk({31'h0, q_oe}, 32'h0, "output enable off");
		apb(1'b0, fco_pkg::FCO_A_STAT, 32'h0);
		chk(v & 32'h7ff, 32'h1, "count suppressed");
		oe_n <= 1'b0;
		i_fco_peer.take_word(q);
		chk({14'h0, q}, 32'h3ffff, "word after suppress");
		chk({31'h0, q_oe}, 32'h1, "output enable on");
		$display("test enables done");
		// pin load of both offsets, then readback as a separate sequence
		ld_n <= 1'b0;
		i_fco_peer.put_word(18'h0000a);
		i_fco_peer.put_word(18'h00014);
		ld_n <= 1'b1;
		apb(1'b0, fco_pkg::FCO_A_EOFF, 32'h0);
		chk(v, 32'ha, "loaded empty offset");
		apb(1'b0, fco_pkg::FCO_A_FOFF, 32'h0);
		chk(v, 32'h14, "loaded full offset");
		ld_n <= 1'b0;
		i_fco_peer.take_word(q);
		chk({14'h0, q}, 32'ha, "readback 0");
		i_fco_peer.take_word(q);
		chk({14'h0, q}, 32'h14, "readback 1");
		ld_n <= 1'b1;
		apb(1'b0, 8'h20, 32'h0);
		chk({31'h0, e}, 32'h1, "unmapped error");
		chk(v, 32'h0, "unmapped data");
		$display("test load done");
		// second reset into standard mode
		mode_n <= 1'b1;
		rstn <= 1'b0;
		repeat (6) @(posedge clock);
		chk({27'h0, ff_n, af_n, hf_n, ae_n, ef_n}, 32'h1c, "reset flags 2");
		rstn <= 1'b1;
		repeat (2) @(posedge clock);
		apb(1'b1, fco_pkg::FCO_A_CTRL, 32'h3f);
		apb(1'b0, fco_pkg::FCO_A_CTRL, 32'h0);
		chk(v, 32'h0, "hidden ctrl");
		apb(1'b0, fco_pkg::FCO_A_EOFF, 32'h0);
		chk(v, 32'(OFF), "offset after reset");
		// retransmit right after reset so no pointer wraps
		for (int i = 1; i <= 3; i++) i_fco_peer.put_word(pat(i));
		for (int i = 1; i <= 3; i++) i_fco_peer.take_word(q);
		@(posedge clock);
		rt <= 1'b1;
		@(posedge clock);
		rt <= 1'b0;
		repeat (2) @(posedge clock);
		apb(1'b0, fco_pkg::FCO_A_STAT, 32'h0);
		chk(v & 32'h7ff, 32'h3, "count retransmit");
		for (int i = 1; i <= 3; i++) begin
			i_fco_peer.take_word(q);
			chk({14'h0, q}, {14'h0, pat(i)}, "reread word");
		end
		// depth-cascaded: a falling retransmit pin must leave the read pointer alone
		apb(1'b1, fco_pkg::FCO_A_CFG, 32'h1);
		apb(1'b0, fco_pkg::FCO_A_CFG, 32'h0);
		chk(v, 32'h1, "cascade cfg");
		@(posedge clock);
		rt <= 1'b1;
		@(posedge clock);
		rt <= 1'b0;
		repeat (2) @(posedge clock);
		apb(1'b0, fco_pkg::FCO_A_STAT, 32'h0);
		chk(v & 32'h7ff, 32'h0, "count cascaded");
		$display("test standard retransmit done");
		wrap_up();
	end
endmodule

// *** fco_fifo.sv ***
/*
 fco_fifo: 18-bit fifo with five occupancy flags, programmable offsets,
 standard/enhanced mode, pin register load and readback, retransmit, and an apb window.
 assumes: write and read ports share clock; apb master follows the usual two-phase protocol.
*/
`timescale 1ns/1ps
module fco_fifo (
	input wire logic clock,
	input wire logic rstn,
	input wire logic enhanced_mode_select_n,
	input wire logic write_enable_n,
	input wire logic write_expansion_in_or_enable2,
	input wire logic [fco_pkg::FCO_WIDTH-1:0] write_data_in,
	input wire logic read_enable_n,
	input wire logic read_expansion_in_or_enable2,
	input wire logic output_enable_n,
	input wire logic register_load_select_n,
	input wire logic first_load_retransmit,
	output logic [fco_pkg::FCO_WIDTH-1:0] read_data_out,
	output logic read_data_oe,
	output logic full_flag_n,
	output logic almost_full_flag_n,
	output logic half_full_flag_n,
	output logic almost_empty_flag_n,
	output logic empty_flag_n,
	output logic write_expansion_out_half_full,
	output logic read_expansion_out_empty2,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);
	// mode capture and configuration
	logic rst_seen_r; // first edge after reset done
	logic enh_r; // enhanced mode latched at release
	logic [5:0] ctrl_r; // control register
	logic [9:0] eoff_r; // almost-empty offset
	logic [9:0] foff_r; // almost-full offset
	logic cfg_cascade_r; // set when depth cascaded
	logic [1:0] li_r; // pin load sequence index
	logic [1:0] li_nxt;
	// pointers and occupancy
	logic [10:0] wr_ptr_r;
	logic [10:0] rd_ptr_r;
	logic [10:0] count_r;
	logic [10:0] wr_ptr_nxt;
	logic [10:0] rd_ptr_nxt;
	logic [10:0] count_nxt;
	logic rt_prev_r; // retransmit pin last cycle
	// flags, active high inside
	logic full_r;
	logic empty_r;
	logic [2:0] pf_stage_r; // extra stage for loose partial flags
	logic [2:0] pf_r; // {af, hf, ae}
	logic [2:0] pf_nxt;
	logic [17:0] dout_r;
	logic [31:0] prdata_r;
	logic [17:0] ram_q;
	logic [17:0] reg_val;
	logic [31:0] rd_mux;

	// request decode
	wire load_act = ~register_load_select_n;
	// standard mode ignores the expansion inputs; enhanced mode ANDs them in
	wire wr_req = ~write_enable_n & (enh_r ? write_expansion_in_or_enable2 : 1'b1);
	// read suppression while outputs are off, when control bit allows it
	wire rd_sup = ctrl_r[fco_pkg::FCO_CB_RDSUP] & output_enable_n;
	wire rd_req = ~read_enable_n & (enh_r ? read_expansion_in_or_enable2 : 1'b1) & ~rd_sup;
	// retransmit on falling pin; a grounded pin never falls
	wire rt_fall = rt_prev_r & ~first_load_retransmit;
	wire retrans = rt_fall & ~cfg_cascade_r & ~load_act;
	wire fifo_wr = wr_req & ~load_act & ~full_r;
	wire fifo_rd = rd_req & ~load_act & ~empty_r & ~retrans;
	wire reg_wr = wr_req & load_act;
	wire reg_rd = rd_req & load_act & ~output_enable_n;
	wire [1:0] li_last = enh_r ? fco_pkg::FCO_LI_CTRL : fco_pkg::FCO_LI_FOFF;

	// next pointers; retransmit relies on no wrap, so count is the write pointer
	assign wr_ptr_nxt = wr_ptr_r + {10'h000, fifo_wr};
	assign rd_ptr_nxt = retrans ? 11'h000 : rd_ptr_r + {10'h000, fifo_rd};
	assign count_nxt = retrans ? wr_ptr_nxt : count_r + {10'h000, fifo_wr} - {10'h000, fifo_rd};

	// partial flag next values
	assign pf_nxt[2] = (fco_pkg::FCO_DEPTH_CNT - count_nxt) <= {1'b0, foff_r};
	assign pf_nxt[1] = count_nxt > fco_pkg::FCO_HALF;
	assign pf_nxt[0] = count_nxt <= {1'b0, eoff_r};

	// pin load index: walks through registers, restarts when load drops
	assign li_nxt = (li_r == li_last) ? fco_pkg::FCO_LI_EOFF : li_r + 2'h1;

	// register readback value for the data pins
	assign reg_val = (li_r == fco_pkg::FCO_LI_EOFF) ? {8'h00, eoff_r} :
		(li_r == fco_pkg::FCO_LI_FOFF) ? {8'h00, foff_r} : {12'h000, ctrl_r};

	// apb decode
	wire apb_setup = psel & ~penable;
	wire apb_acc = psel & penable;
	wire a_ctrl = paddr == fco_pkg::FCO_A_CTRL;
	wire a_eoff = paddr == fco_pkg::FCO_A_EOFF;
	wire a_foff = paddr == fco_pkg::FCO_A_FOFF;
	wire a_stat = paddr == fco_pkg::FCO_A_STAT;
	wire a_cfg = paddr == fco_pkg::FCO_A_CFG;
	wire a_ok = a_ctrl | a_eoff | a_foff | a_stat | a_cfg;
	wire apb_wr = apb_acc & pwrite & a_ok;
	// control reads as zero in standard mode: hidden from software
	assign rd_mux = a_ctrl ? (enh_r ? {26'h0000000, ctrl_r} : 32'h00000000) :
		a_eoff ? {22'h000000, eoff_r} :
		a_foff ? {22'h000000, foff_r} :
		a_stat ? {15'h0000, enh_r, full_flag_n, almost_full_flag_n, half_full_flag_n,
			almost_empty_flag_n, empty_flag_n, count_r} :
		a_cfg ? {31'h00000000, cfg_cascade_r} : 32'h00000000;

	// storage
	fco_ram u_ram (
		.clock(clock),
		.wr_en(fifo_wr),
		.wr_addr(wr_ptr_r[9:0]),
		.wr_data(write_data_in),
		.rd_addr(rd_ptr_r[9:0]),
		.rd_data(ram_q)
	);

	// mode strap caught on first edge after release, not under reset
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rst_seen_r <= 1'b0;
			enh_r <= 1'b0;
		end else if (!rst_seen_r) begin
			rst_seen_r <= 1'b1;
			enh_r <= ~enhanced_mode_select_n;
		end
	end

	// programmable registers: pin load wins over apb in the same cycle
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			ctrl_r <= fco_pkg::FCO_CTRL_STD_RST;
			eoff_r <= fco_pkg::FCO_DEF_OFF;
			foff_r <= fco_pkg::FCO_DEF_OFF;
			cfg_cascade_r <= 1'b0;
			li_r <= fco_pkg::FCO_LI_EOFF;
		end else begin
			// enhanced default sets all six bits at the strap edge
			if (!rst_seen_r) begin
				ctrl_r <= enhanced_mode_select_n ? fco_pkg::FCO_CTRL_STD_RST : fco_pkg::FCO_CTRL_ENH_RST;
			end else if (reg_wr && li_r == fco_pkg::FCO_LI_CTRL) begin
				ctrl_r <= write_data_in[5:0];
			end else if (apb_wr && a_ctrl && enh_r) begin
				ctrl_r <= pwdata[5:0];
			end
			// offsets
			if (reg_wr && li_r == fco_pkg::FCO_LI_EOFF) begin
				eoff_r <= write_data_in[9:0];
			end else if (apb_wr && a_eoff) begin
				eoff_r <= pwdata[9:0];
			end
			if (reg_wr && li_r == fco_pkg::FCO_LI_FOFF) begin
				foff_r <= write_data_in[9:0];
			end else if (apb_wr && a_foff) begin
				foff_r <= pwdata[9:0];
			end
			if (apb_wr && a_cfg) begin
				cfg_cascade_r <= pwdata[0];
			end
			// load index; a write and a read in one cycle share one step
			if (!load_act) begin
				li_r <= fco_pkg::FCO_LI_EOFF;
			end else if (reg_wr || reg_rd) begin
				li_r <= li_nxt;
			end
		end
	end

	// pointers, count, retransmit edge
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			wr_ptr_r <= 11'h000;
			rd_ptr_r <= 11'h000;
			count_r <= 11'h000;
			rt_prev_r <= 1'b0;
		end else begin
			wr_ptr_r <= wr_ptr_nxt;
			rd_ptr_r <= rd_ptr_nxt;
			count_r <= count_nxt;
			rt_prev_r <= first_load_retransmit;
		end
	end

	// flags; partial flags take one more cycle unless flag sync bit is set
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			full_r <= 1'b0;
			empty_r <= 1'b1;
			pf_stage_r <= fco_pkg::FCO_PF_RST;
			pf_r <= fco_pkg::FCO_PF_RST;
		end else begin
			full_r <= count_nxt == fco_pkg::FCO_DEPTH_CNT;
			empty_r <= count_nxt == 11'h000;
			pf_stage_r <= pf_nxt;
			pf_r <= ctrl_r[fco_pkg::FCO_CB_FLAGSYNC] ? pf_nxt : pf_stage_r;
		end
	end

	// output data: fifo word or register readback, held otherwise
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			dout_r <= 18'h00000;
		end else if (fifo_rd) begin
			dout_r <= ram_q;
		end else if (reg_rd) begin
			dout_r <= reg_val;
		end
	end

	// apb read data captured in setup, shown in access
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			prdata_r <= 32'h00000000;
		end else if (apb_setup) begin
			prdata_r <= rd_mux;
		end
	end

	// pins; active-low flag outputs
	assign read_data_out = dout_r;
	assign read_data_oe = ~output_enable_n;
	assign full_flag_n = ~full_r;
	assign empty_flag_n = ~empty_r;
	assign almost_full_flag_n = ~pf_r[2];
	assign half_full_flag_n = ~pf_r[1];
	assign almost_empty_flag_n = ~pf_r[0];
	assign write_expansion_out_half_full = ~pf_r[1];
	assign read_expansion_out_empty2 = ~empty_r;
	// zero-wait slave; unmapped addresses answer with an error
	assign prdata = prdata_r;
	assign pready = 1'b1;
	assign pslverr = apb_acc & ~a_ok;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rstn);

	chk_no_write_full: assert property (
		(!full_flag_n && !retrans) |=> wr_ptr_r == $past(wr_ptr_r) && count_r <= $past(count_r))
		else $error("write accepted while full");

	chk_retrans_ptrs: assert property (
		retrans |=> rd_ptr_r == 11'h000 && wr_ptr_r == $past(wr_ptr_r) + {10'h000, $past(fifo_wr)})
		else $error("retransmit pointer update wrong");

	chk_rt_grounded: assert property (
		(!first_load_retransmit && !rt_prev_r) || cfg_cascade_r |=> rd_ptr_r >= $past(rd_ptr_r))
		else $error("read pointer moved back without retransmit");

	chk_half_level: assert property (
		ctrl_r[fco_pkg::FCO_CB_FLAGSYNC] && $past(ctrl_r[fco_pkg::FCO_CB_FLAGSYNC])
		|-> half_full_flag_n == !(count_r > fco_pkg::FCO_HALF))
		else $error("half full flag mismatch");

	chk_almost_empty: assert property (
		ctrl_r[fco_pkg::FCO_CB_FLAGSYNC] && $past(ctrl_r[fco_pkg::FCO_CB_FLAGSYNC]) && $stable(eoff_r)
		|-> almost_empty_flag_n == !(count_r <= {1'b0, eoff_r}))
		else $error("almost empty flag mismatch");

	chk_full_empty: assert property (
		empty_flag_n == (count_r != 11'h000) && full_flag_n == (count_r != fco_pkg::FCO_DEPTH_CNT))
		else $error("full or empty flag mismatch");

	chk_std_hidden: assert property (
		rst_seen_r && !enh_r |-> ctrl_r == fco_pkg::FCO_CTRL_STD_RST && (!a_ctrl || rd_mux == 32'h00000000))
		else $error("control changed in standard mode");

	chk_enh_default: assert property (
		$rose(rst_seen_r) && enh_r && !$past(load_act) |-> ctrl_r == fco_pkg::FCO_CTRL_ENH_RST)
		else $error("enhanced default not set");

	chk_enable2_and: assert property (
		enh_r && !write_expansion_in_or_enable2 |=> wr_ptr_r == $past(wr_ptr_r))
		else $error("write taken with enable2 low");

	chk_pin_load: assert property (
		reg_wr && li_r == fco_pkg::FCO_LI_EOFF |=> eoff_r == $past(write_data_in[9:0]) ##1 1'b1)
		else $error("offset not loaded from pins");

	chk_reg_readback: assert property (
		reg_rd && !fifo_rd |=> read_data_out == $past(reg_val))
		else $error("register readback wrong");

	chk_read_word: assert property (
		fifo_rd |=> read_data_out == $past(ram_q))
		else $error("read data not presented");
endmodule

// *** fco_peer.sv ***
/*
 fco_peer: producer and consumer logic on the fifo write and read ports.
 assumes: shares the fifo clock; the caller sequences load and retransmit.
*/
`timescale 1ns/1ps
module fco_peer (
	input wire logic clock,
	output logic write_enable_n,
	output logic [fco_pkg::FCO_WIDTH-1:0] write_data_in,
	output logic read_enable_n,
	input wire logic [fco_pkg::FCO_WIDTH-1:0] read_data_out
);
	// idle: no request, bus shows a non-word pattern
	initial begin
		write_enable_n = 1'b1;
		write_data_in = 18'h15555;
		read_enable_n = 1'b1;
	end
	// one word per call; data inverted after release so a stale word never looks valid
	task automatic put_word(input logic [fco_pkg::FCO_WIDTH-1:0] d);
		@(posedge clock);
		write_enable_n <= 1'b0;
		write_data_in <= d;
		@(posedge clock);
		write_enable_n <= 1'b1;
		write_data_in <= ~d;
	endtask
	// request held for one edge; word taken once it has settled
	task automatic take_word(output logic [fco_pkg::FCO_WIDTH-1:0] q);
		@(posedge clock);
		read_enable_n <= 1'b0;
		@(posedge clock);
		read_enable_n <= 1'b1;
		#1 q = read_data_out;
	endtask
endmodule

// *** fco_pkg.sv ***
/*
 fco_pkg: constants shared by the programmable-flag fifo and its storage array.
 assumes: one clock domain; depth variant chosen by FCO_DEPTH (512 or 1024).
*/
package fco_pkg;
	// data width and depth variant
	localparam int FCO_WIDTH = 18;
	localparam int FCO_DEPTH = 1024;
	localparam int FCO_AW = 10;
	localparam int FCO_PW = 11;
	// occupancy figures at pointer width
	localparam logic [10:0] FCO_DEPTH_CNT = 11'(FCO_DEPTH);
	localparam logic [10:0] FCO_HALF = 11'(FCO_DEPTH / 2);
	// default almost-full / almost-empty offsets per variant
	localparam logic [9:0] FCO_OFF_512 = 10'h03f;
	localparam logic [9:0] FCO_OFF_1024 = 10'h07f;
	localparam logic [9:0] FCO_DEF_OFF = (FCO_DEPTH == 512) ? FCO_OFF_512 : FCO_OFF_1024;
	// control register: reset values and bit positions
	localparam int FCO_CTRL_W = 6;
	localparam logic [5:0] FCO_CTRL_STD_RST = 6'h00;
	localparam logic [5:0] FCO_CTRL_ENH_RST = 6'h3f;
	localparam int FCO_CB_FLAGSYNC = 0;
	localparam int FCO_CB_RDSUP = 1;
	// pin-side register load sequence indices
	localparam logic [1:0] FCO_LI_EOFF = 2'h0;
	localparam logic [1:0] FCO_LI_FOFF = 2'h1;
	localparam logic [1:0] FCO_LI_CTRL = 2'h2;
	// apb byte offsets
	localparam logic [7:0] FCO_A_CTRL = 8'h00;
	localparam logic [7:0] FCO_A_EOFF = 8'h04;
	localparam logic [7:0] FCO_A_FOFF = 8'h08;
	localparam logic [7:0] FCO_A_STAT = 8'h0c;
	localparam logic [7:0] FCO_A_CFG = 8'h10;
	// partial flag reset state, active high internally: {af, hf, ae}
	localparam logic [2:0] FCO_PF_RST = 3'h1;
endpackage

// *** fco_ram.sv ***
/*
 fco_ram: word storage of the fifo, synchronous write, combinational read.
 assumes: caller never writes and reads the same location in one cycle expecting new data.
*/
`timescale 1ns/1ps
module fco_ram (
	input wire logic clock,
	input wire logic wr_en,
	input wire logic [fco_pkg::FCO_AW-1:0] wr_addr,
	input wire logic [fco_pkg::FCO_WIDTH-1:0] wr_data,
	input wire logic [fco_pkg::FCO_AW-1:0] rd_addr,
	output logic [fco_pkg::FCO_WIDTH-1:0] rd_data
);
	// storage, no reset: contents are undefined until written
	logic [fco_pkg::FCO_WIDTH-1:0] mem [fco_pkg::FCO_DEPTH];

	// write port
	always_ff @(posedge clock) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	// read port, registered by the caller
	assign rd_data = mem[rd_addr];
endmodule
